/* dv/hpic_dev_model.sv */
/*
 * Behavioural model of the eight-level interrupt controller on the host pins.
 * Assumes fixed priority, auto end of service and one request per line; the
 * bench tells the model whether acknowledge sequences have two or three pulses.
 */
`timescale 1ns/1ps
module hpic_dev_model (
    input  wire hpic_pkg::hpic_pins_t pins,
    input  wire logic [7:0]           reqLines,
    input  wire logic                 strapOut,
    input  wire logic                 strapOe,
    input  wire logic                 threePulse,
    output logic      [7:0]           dataBus,
    output logic      [2:0]           cascadeIdLines,
    output logic                      cpuIrq,
    output logic                      progPin
);
    import hpic_pkg::*;
    logic [7:0] cmd0;
    logic [7:0] cmd1;
    logic [2:0] level;
    logic [1:0] ackIdx;
    logic [1:0] ackNext;
    logic [1:0] lastIdx;
    logic [7:0] inSvc;
    logic       devDrive;
    logic [7:0] devData;

    function automatic logic [2:0] pick(input logic [7:0] r);
        int k;
        pick = 3'h7;
        for (k = 7; k >= 0; k--)
            if (r[k]) pick = 3'(k);
    endfunction

    initial
    begin
        cmd0 = 8'h00;
        cmd1 = 8'h00;
        level = 3'h7;
        ackIdx = 2'h0;
        ackNext = 2'h0;
        inSvc = 8'h00;
    end

    assign lastIdx = threePulse ? 2'h2 : 2'h1;

    always @(posedge pins.storeStrobeN)
        if (!pins.selectN)
        begin
            if (pins.portSelect) cmd1 <= dataBus;
            else cmd0 <= dataBus;
        end

    // Winner frozen at the first pulse; an empty request set answers as level 7
    always @(negedge pins.irqAckN)
    begin
        if (ackNext == 2'h0)
        begin
            level <= pick(reqLines);
            if (|reqLines) inSvc[pick(reqLines)] <= 1'b1;
        end
        ackIdx  <= ackNext;
        ackNext <= (ackNext == lastIdx) ? 2'h0 : ackNext + 2'h1;
    end

    // Auto end of service: the level leaves service as the final pulse ends
    always @(posedge pins.irqAckN)
        if (ackIdx == lastIdx) inSvc <= 8'h00;

    assign devDrive = (!pins.selectN && !pins.fetchStrobeN) ||
                      (!pins.irqAckN && (threePulse || ackIdx != 2'h0));
    assign devData = pins.irqAckN ? (pins.portSelect ? cmd1 : cmd0) :
                     (ackIdx == 2'h1) ? {cmd0[7:3], level} :
                     ((ackIdx == 2'h0) ? cmd1 : cmd0);
    // Released bus shows the inverse pattern so a stale sample cannot pass
    assign dataBus = pins.dataOe ? pins.dataOut : (devDrive ? devData : ~devData);
    // Only a request that outranks every level in service interrupts the host
    assign cpuIrq = (|reqLines) &&
                    ((inSvc == 8'h00) || (pick(reqLines) < pick(inSvc)));
    assign progPin = strapOe ? strapOut : devDrive;
    assign cascadeIdLines = (strapOe && strapOut) ? level : ~level;
endmodule

/* dv/tb.sv */
/*
 * Self-checking bench for hpic_host driving the controller model over AXI4-Lite.
 * Assumes the register map and timing of the hpic package, 100 MHz clock.
 */
`timescale 1ns/1ps
module tb;
    import hpic_pkg::*;
    logic             sys_clk;
    logic             rst_b;
    logic [7:0]       awAddr, arAddr, reqLines, base, alt, req, d;
    logic             awValid, wValid, bReady, arValid, rReady;
    logic             awReady, wReady, bValid, arReady, rValid;
    logic [31:0]      wData, rData, rd32, want;
    logic [1:0]       bResp, rResp, resp;
    hpic_pins_t       pins;
    logic [7:0]       bus;
    logic [2:0]       cas;
    logic             irq, prog, strapOut, strapOe, threePulse;
    logic [31:0]      seed = 32'h64437822;
    int               numErrors, checked, i;

    task automatic summarize();
        $display("errors %0d checks %0d", numErrors, checked);
        if (numErrors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic hang();
        numErrors++;
        $display("MISMATCH at %0t: wait ran out", $time);
        summarize();
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            numErrors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic axWrite(input logic [7:0] a, input logic [31:0] dv);
        int n;
        @(posedge sys_clk);
        awAddr  <= a;
        wData   <= dv;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        for (n = 0; n < 100 && bValid !== 1'b1; n++)
        begin
            @(posedge sys_clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end
        if (n == 100) hang();
        resp = bResp;
        bReady <= 1'b0;
    endtask

    task automatic axRead(input logic [7:0] a);
        int n;
        @(posedge sys_clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        for (n = 0; n < 100 && rValid !== 1'b1; n++)
        begin
            @(posedge sys_clk);
            if (arReady) arValid <= 1'b0;
        end
        if (n == 100) hang();
        rd32 = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask

    task automatic waitIdle();
        int n;
        for (n = 0; n < 60; n++)
        begin
            axRead(OFS_STATUS);
            if (rd32[STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n == 60) hang();
    endtask

    function automatic logic [2:0] lvlOf(input logic [7:0] r);
        int k;
        lvlOf = 3'h7;
        for (k = 7; k >= 0; k--)
            if (r[k]) lvlOf = 3'(k);
    endfunction

    hpic_host u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .picPins(pins),
        .picDataIn(bus), .cascadeIdLines(cas), .cpuIrqIn(irq), .slaveProgBufEnIn(prog),
        .strapOut(strapOut), .strapOe(strapOe));

    hpic_dev_model u_dev (
        .pins(pins), .reqLines(reqLines), .strapOut(strapOut), .strapOe(strapOe),
        .threePulse(threePulse),
        .dataBus(bus), .cascadeIdLines(cas), .cpuIrq(irq), .progPin(prog));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {rst_b, awAddr, arAddr, reqLines, base, alt, threePulse} = '0;
        {awValid, wValid, bReady, arValid, rReady, wData} = '0;
        numErrors = 0;
        checked = 0;
        repeat (8) @(posedge sys_clk);
        chk({pins, strapOut, strapOe}, {PINS_IDLE, 2'b11}, "reset pins");
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        axRead(OFS_CTRL);
        chk(rd32, {29'h0, CTRL_RESET}, "ctrl reset");
        axWrite(8'h18, 32'h0);
        chk(resp, RESP_SLVERR, "unmapped write");
        axRead(8'h1C);
        chk({rd32, resp}, {32'h0, RESP_SLVERR}, "unmapped read");
        for (i = 0; i < 4; i++)
        begin
            d = 8'($random(seed));
            axWrite(OFS_WRITE, {23'h0, i[0], d});
            waitIdle();
            chk(i[0] ? u_dev.cmd1 : u_dev.cmd0, d, "command");
            if (!i[0]) base = d;
            else alt = d;
            axWrite(OFS_READ, {23'h0, i[0], 8'h00});
            waitIdle();
            chk(rd32[STAT_RDATA_LSB +: 8], d, "status byte");
        end
        axWrite(OFS_READ, 32'h0);
        axWrite(OFS_ACK, 32'h0);
        chk(resp, RESP_SLVERR, "start while busy");
        waitIdle();
        // Empty set, level 7 alone, random sets; the last one in call style
        for (i = 0; i < 7; i++)
        begin
            req = (i == 0) ? 8'h00 : ((i == 1) ? 8'h80 : 8'($random(seed)));
            if (i == 6)
            begin
                threePulse <= 1'b1;
                axWrite(OFS_CTRL, {29'h0, CTRL_RESET} | (32'h1 << CTRL_THREE_BIT));
            end
            reqLines <= req;
            repeat (4) @(posedge sys_clk);
            axRead(OFS_STATUS);
            chk(rd32[STAT_IRQ_BIT], |req, "irq level");
            axWrite(OFS_ACK, 32'h0);
            waitIdle();
            chk(rd32[STAT_CAS_LSB +: 3], lvlOf(req), "cascade id");
            axRead(OFS_VECTOR);
            want = {24'h0, base[7:3], lvlOf(req)};
            if (i == 6) want = {8'h00, alt, base[7:3], lvlOf(req), base};
            chk(rd32, want, "vector");
        end
        axWrite(OFS_CTRL, 32'h6);
        repeat (4) @(posedge sys_clk);
        axRead(OFS_STATUS);
        chk({strapOe, rd32[STAT_SPEN_BIT]}, 2'b00, "buffered pin");
        axWrite(OFS_CTRL, 32'h0);
        repeat (4) @(posedge sys_clk);
        axRead(OFS_STATUS);
        chk({strapOe, strapOut, rd32[STAT_SPEN_BIT]}, 3'b100, "slave strap");
        summarize();
    end
endmodule

/* rtl/hpic_host.sv */
/*
 * Host-side pin driver for an eight-level priority interrupt controller:
 * AXI4-Lite register slave, command write, status read and acknowledge
 * pulse sequences on the controller's pins.
 * Assumes the controller sits directly on these pins; bidirectional wires are
 * resolved outside from the enables.
 */
// Functional notes
// - Host lowers write strobe with select low, controller captures data.
// - Unbuffered, program pin high means master, low means slave.
// - Edge mode: requester rises and holds high until acknowledged.
// - Host issues acknowledge pulses; controller places vector bytes.
// - Host wires port select to lowest or next address line; this host drives it from command data bit 8 (CMD_PORT_BIT).
`timescale 1ns/1ps
module hpic_host (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output hpic_pkg::hpic_pins_t     picPins,
    input  wire logic [7:0]          picDataIn,
    input  wire logic [2:0]          cascadeIdLines,
    input  wire logic                cpuIrqIn,
    input  wire logic                slaveProgBufEnIn,
    output logic                     strapOut,
    output logic                     strapOe
);
    import hpic_pkg::*;

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic [1:0]  rstPipe_reg;
    logic        rstSync;
    logic [12:0] pinSync;
    logic [7:0]  dataSync;
    logic [2:0]  casSync;
    logic        irqSync;
    logic        spEnSync;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rstPipe_reg <= 2'h0;
        else
            rstPipe_reg <= {rstPipe_reg[0], 1'h1};
    end
    assign rstSync = rstPipe_reg[1];

    hpic_sync #(.W(13)) uSync (
        .clk  (sys_clk),
        .rstN (rstSync),
        .d    ({slaveProgBufEnIn, cpuIrqIn, cascadeIdLines, picDataIn}),
        .q    (pinSync)
    );
    assign {spEnSync, irqSync, casSync, dataSync} = pinSync;

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == OFS_CTRL) || (a == OFS_WRITE) || (a == OFS_READ) ||
                   (a == OFS_ACK) || (a == OFS_STATUS) || (a == OFS_VECTOR);
    endfunction

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic        awHeld_reg;
    logic        wHeld_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [2:0]  ctrl_reg;
    logic        wrFire;
    logic        busy;
    logic        startGo;
    hpic_op_t    startOp;

    assign wrFire  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign startGo = wrFire && !busy &&
                     ((awAddr_reg == OFS_WRITE) || (awAddr_reg == OFS_READ) ||
                      (awAddr_reg == OFS_ACK));
    assign startOp = (awAddr_reg == OFS_WRITE) ? OP_WRITE :
                     (awAddr_reg == OFS_READ) ? OP_READ : OP_ACK;

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            s_axi_awready <= 1'h0;
            s_axi_wready  <= 1'h0;
            awHeld_reg    <= 1'h0;
            wHeld_reg     <= 1'h0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h0000_0000;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid && !awHeld_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_wvalid && !wHeld_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_reg <= 1'h1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_reg <= 1'h1;
                wData_reg <= s_axi_wdata;
            end
            if (wrFire)
            begin
                awHeld_reg   <= 1'h0;
                wHeld_reg    <= 1'h0;
                s_axi_bvalid <= 1'h1;
                // A start while a sequence runs is refused, not queued
                if (!isMapped(awAddr_reg) || (busy && awAddr_reg != OFS_CTRL &&
                    awAddr_reg != OFS_STATUS && awAddr_reg != OFS_VECTOR))
                    s_axi_bresp <= RESP_SLVERR;
                else
                    s_axi_bresp <= RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
            ctrl_reg <= CTRL_RESET;
        else if (wrFire && awAddr_reg == OFS_CTRL)
            ctrl_reg <= wData_reg[2:0];
    end

    // ************************************************************
    // Pin sequencer
    // ************************************************************
    hpic_state_t state_reg;
    hpic_op_t    op_reg;
    logic [7:0]  cnt_reg;
    logic [1:0]  pulse_reg;
    logic [1:0]  lastPulse;
    logic        portSel_reg;
    logic [7:0]  wrByte_reg;
    logic [7:0]  rdByte_reg;
    logic [23:0] vector_reg;
    hpic_pins_t  pinsNext;

    assign busy      = (state_reg != ST_IDLE);
    // Three pulses for the call-style sequence, two for the pointer style
    assign lastPulse = ctrl_reg[CTRL_THREE_BIT] ? 2'h2 : 2'h1;

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            state_reg   <= ST_IDLE;
            op_reg      <= OP_WRITE;
            cnt_reg     <= 8'h00;
            pulse_reg   <= 2'h0;
            portSel_reg <= 1'h0;
            wrByte_reg  <= 8'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (startGo)
                    begin
                        state_reg   <= ST_SETUP;
                        op_reg      <= startOp;
                        cnt_reg     <= SETUP_CYC - 8'h01;
                        pulse_reg   <= 2'h0;
                        portSel_reg <= wData_reg[CMD_PORT_BIT];
                        wrByte_reg  <= wData_reg[7:0];
                    end
                end
                ST_SETUP, ST_GAP:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                    begin
                        state_reg <= ST_STROBE;
                        cnt_reg   <= STROBE_CYC - 8'h01;
                    end
                end
                ST_STROBE:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                    begin
                        state_reg <= ST_HOLD;
                        cnt_reg   <= HOLD_CYC - 8'h01;
                    end
                end
                ST_HOLD:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                    begin
                        if (op_reg == OP_ACK && pulse_reg != lastPulse)
                        begin
                            state_reg <= ST_GAP;
                            cnt_reg   <= GAP_CYC - 8'h01;
                            pulse_reg <= pulse_reg + 2'h1;
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Bytes are taken late in the strobe, well after the two-flop delay
    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            rdByte_reg <= 8'h00;
            vector_reg <= 24'h00_0000;
        end
        else if (state_reg == ST_STROBE && cnt_reg == 8'h00)
        begin
            if (op_reg == OP_READ)
                rdByte_reg <= dataSync;
            else if (op_reg == OP_ACK)
            begin
                if (pulse_reg == 2'h0)
                    vector_reg <= 24'h00_0000;
                // Pointer style: the first pulse finds the bus floating
                if (ctrl_reg[CTRL_THREE_BIT] || pulse_reg != 2'h0)
                    vector_reg <= {vector_reg[15:0], dataSync};
            end
        end
    end

    always_comb
    begin
        pinsNext            = PINS_IDLE;
        pinsNext.portSelect = portSel_reg;
        if (state_reg == ST_SETUP || state_reg == ST_STROBE || state_reg == ST_HOLD ||
            state_reg == ST_GAP)
        begin
            case (op_reg)
                OP_WRITE:
                begin
                    pinsNext.selectN      = 1'h0;
                    pinsNext.dataOe       = 1'h1;
                    pinsNext.dataOut      = wrByte_reg;
                    pinsNext.storeStrobeN = (state_reg != ST_STROBE);
                end
                OP_READ:
                begin
                    pinsNext.selectN      = 1'h0;
                    pinsNext.fetchStrobeN = (state_reg != ST_STROBE);
                end
                OP_ACK:
                    pinsNext.irqAckN = (state_reg != ST_STROBE);
                default:
                    pinsNext = PINS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            picPins  <= PINS_IDLE;
            strapOut <= 1'h1;
            strapOe  <= 1'h1;
        end
        else
        begin
            picPins  <= pinsNext;
            // Buffered: the pin is the controller's transceiver enable
            strapOe  <= !ctrl_reg[CTRL_BUF_BIT];
            strapOut <= ctrl_reg[CTRL_MASTER_BIT];
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    logic [31:0] rdMux;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        case (s_axi_araddr)
            OFS_CTRL:   rdMux[2:0] = ctrl_reg;
            OFS_STATUS:
            begin
                rdMux[STAT_BUSY_BIT]                    = busy;
                rdMux[STAT_IRQ_BIT]                     = irqSync;
                rdMux[STAT_SPEN_BIT]                    = spEnSync;
                rdMux[STAT_CAS_LSB+2:STAT_CAS_LSB]      = casSync;
                rdMux[STAT_RDATA_LSB+7:STAT_RDATA_LSB]  = rdByte_reg;
            end
            OFS_VECTOR: rdMux[23:0] = vector_reg;
            default:    rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'h1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'h0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [7:0] storeLen_reg;
    logic [7:0] ackLen_reg;

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            storeLen_reg <= 8'h00;
            ackLen_reg   <= 8'h00;
        end
        else
        begin
            storeLen_reg <= picPins.storeStrobeN ? 8'h00 : storeLen_reg + 8'h01;
            ackLen_reg   <= picPins.irqAckN ? 8'h00 : ackLen_reg + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstSync);

    sequence sAckStart;
        $fell(picPins.irqAckN);
    endsequence
    sequence sWriteStart;
        $fell(picPins.storeStrobeN);
    endsequence

    a_store_selected: assert property (!picPins.storeStrobeN |-> !picPins.selectN)
        else $error("write strobe without select");
    a_fetch_selected: assert property (!picPins.fetchStrobeN |-> !picPins.selectN)
        else $error("read strobe without select");
    a_ack_unselected: assert property (sAckStart |-> picPins.selectN[*3])
        else $error("select low during acknowledge");
    a_bus_released: assert property (picPins.dataOe |-> picPins.fetchStrobeN && picPins.irqAckN)
        else $error("host drives bus while controller may drive");
    a_write_data_held: assert property (sWriteStart |-> picPins.dataOe && $stable(picPins.dataOut))
        else $error("write data not steady at strobe");
    a_store_width: assert property ($rose(picPins.storeStrobeN) |-> storeLen_reg == STROBE_CYC)
        else $error("write strobe width wrong");
    a_ack_width: assert property ($rose(picPins.irqAckN) |-> ackLen_reg == STROBE_CYC)
        else $error("acknowledge pulse width wrong");
    a_ack_count: assert property ($fell(busy) && op_reg == OP_ACK |-> pulse_reg == lastPulse)
        else $error("acknowledge pulse count wrong");
    a_strap_mode: assert property (##1 strapOe == !$past(ctrl_reg[CTRL_BUF_BIT]))
        else $error("strap drive does not follow buffered mode");

endmodule

/* rtl/hpic_pkg.sv */
/*
 * Shared constants, types and register map for the host-side driver of an
 * eight-level vectored priority interrupt controller.
 * Assumes a 100 MHz system clock and a controller wired straight to the pins.
 */
package hpic_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ   = 100;
    localparam int SETUP_NS  = 50;
    localparam int STROBE_NS = 240;
    localparam int HOLD_NS   = 30;
    localparam int GAP_NS    = 200;
    localparam logic [7:0] SETUP_CYC  = 8'((SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] HOLD_CYC   = 8'((HOLD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] GAP_CYC    = 8'((GAP_NS * CLK_MHZ + 999) / 1000);

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WRITE  = 8'h04;
    localparam logic [7:0] OFS_READ   = 8'h08;
    localparam logic [7:0] OFS_ACK    = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_VECTOR = 8'h14;

    localparam int CTRL_THREE_BIT  = 0;
    localparam int CTRL_BUF_BIT    = 1;
    localparam int CTRL_MASTER_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h4;
    localparam int CMD_PORT_BIT    = 8;

    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_IRQ_BIT   = 1;
    localparam int STAT_SPEN_BIT  = 2;
    localparam int STAT_CAS_LSB   = 4;
    localparam int STAT_RDATA_LSB = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP} hpic_state_t;
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_ACK} hpic_op_t;

    typedef struct packed {
        logic       selectN;
        logic       storeStrobeN;
        logic       fetchStrobeN;
        logic       portSelect;
        logic       irqAckN;
        logic       dataOe;
        logic [7:0] dataOut;
    } hpic_pins_t;

    localparam hpic_pins_t PINS_IDLE = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'h00};

endpackage

/* rtl/hpic_sync.sv */
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes each bit is a slow level; no bus coherence across bits is implied.
 */
`timescale 1ns/1ps
module hpic_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstN,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule
